// >>> include/flash_ctrl_consts.svh
// constants for the flash fault and converter control block
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH
`define DEV_ADDR 7'h30
`define REG_INFO 8'h00
`define REG_TIMER 8'h02
`define REG_CURRENT 8'h03
`define REG_OUT_CTL 8'h04
`define REG_FAULT 8'h05
`define REG_IND_CFG 8'h07
`define REG_ADC 8'h08
`define REG_LAST 8'h09
`define OC_HW_STROBE 2
`define OC_OUT_EN 3
`define OC_LEVEL 5
`define IC_ADAPTIVE_OVERVOLT_MODE 7
`define IC_HARD_ILIM 6
`define P2_CFG_LO 6
`define FB_OVP 7
`define FB_SHORT 6
`define FB_HOT 5
`define FB_TIMEOUT 4
`define FB_TXMASK 3
`define FB_INDLED 2
`define FB_ILIM 1
`define FB_DCLIM 0
`define RES_LO 2
`define RST_TIMER 8'h0F
`define RST_CURRENT 8'h03
`define RST_OTHER 8'h00
`define CONV_TIME_US 1000
`define CLK_MHZ 40
`define CONV_CYCLES (`CONV_TIME_US * `CLK_MHZ)
`endif

// >>> include/flash_ctrl_pkg.sv
// types for the flash fault and converter control block
package flash_ctrl_pkg;
  typedef enum logic [1:0] {LM_STANDBY, LM_FIVE_VOLT, LM_ASSIST, LM_FLASH} light_mode_type;
  typedef enum logic [1:0] {ADC_OFF, ADC_LED_VF, ADC_DIE_TEMP, ADC_EXT} adc_mode_type;
  typedef enum logic [1:0] {P2_HIZ, P2_INDICATOR, P2_TXMASK, P2_ANALOG} pin_cfg_type;
  typedef enum logic [1:0] {CV_IDLE, CV_ARMED, CV_WAIT_FLASH, CV_CONV} conv_state_type;
  typedef enum logic [3:0] {
    LK_IDLE, LK_DEV, LK_SUB, LK_WDATA, LK_ACK_DEV, LK_ACK_SUB, LK_ACK_WR, LK_RDATA, LK_WAIT
  } link_state_type;
  typedef struct packed {
    logic en; logic uvlo; logic ovp; logic short_det; logic hot; logic ind_fault;
    logic ilim; logic tx1; logic tx2; logic dclim; logic strobe; logic timer_done;
    logic pre_expiry; logic [3:0] adc_code;
  } pins_type;
  typedef struct packed {
    pins_type p1; pins_type p2; pins_type p3;
    logic wt1; logic wt2; logic wt3; logic rt1; logic rt2; logic rt3;
    logic [9:0][7:0] regs;
    logic [7:0] rd_data; logic rd_ack;
    conv_state_type conv_st; logic [16:0] cnt; logic adc_run; logic [1:0] adc_chan;
    logic drv_en; logic five_v; logic ovp_lim;
  } core_state_type;
  typedef struct packed {
    logic rs1; logic rs2; logic scl1; logic scl2; logic scl3; logic sda1; logic sda2; logic sda3;
    link_state_type st; logic [3:0] cnt; logic [7:0] sh; logic [7:0] sub; logic rw;
    logic wr_tgl; logic [7:0] wr_data; logic rd_tgl; logic ak1; logic ak2; logic ak3;
    logic [7:0] tx; logic sda_oe; logic sda_lvl;
  } link_reg_type;
endpackage : flash_ctrl_pkg

// >>> rtl/i2c_link_slave.sv
// serial register link slave running on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_consts.svh"
module i2c_link_slave (
  input wire logic link_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_tgl,
  output logic [7:0] sub_addr,
  output logic [7:0] wr_data,
  output logic rd_tgl,
  input wire logic [7:0] rd_data,
  input wire logic rd_ack_tgl
);
  flash_ctrl_pkg::link_reg_type s_ff, nxt_s;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rs1 = rst;
    nxt_s.rs2 = s_ff.rs1;
    nxt_s.scl1 = scl_in;
    nxt_s.scl2 = s_ff.scl1;
    nxt_s.scl3 = s_ff.scl2;
    nxt_s.sda1 = sda_in;
    nxt_s.sda2 = s_ff.sda1;
    nxt_s.sda3 = s_ff.sda2;
    nxt_s.ak1 = rd_ack_tgl;
    nxt_s.ak2 = s_ff.ak1;
    nxt_s.ak3 = s_ff.ak2;
    scl_rise = s_ff.scl2 & ~s_ff.scl3;
    scl_fall = ~s_ff.scl2 & s_ff.scl3;
    start_seen = s_ff.scl2 & s_ff.scl3 & s_ff.sda3 & ~s_ff.sda2;
    stop_seen = s_ff.scl2 & s_ff.scl3 & ~s_ff.sda3 & s_ff.sda2;
    // read data only taken once the core's answer toggle has crossed
    if (s_ff.ak2 ^ s_ff.ak3) begin
      nxt_s.tx = rd_data;
    end
    if (start_seen) begin
      nxt_s.st = flash_ctrl_pkg::LK_DEV;
      nxt_s.cnt = 4'h0;
      nxt_s.sda_oe = 1'b0;
    end else if (stop_seen) begin
      nxt_s.st = flash_ctrl_pkg::LK_IDLE;
      nxt_s.sda_oe = 1'b0;
    end else if (scl_rise && (s_ff.st == flash_ctrl_pkg::LK_DEV ||
                 s_ff.st == flash_ctrl_pkg::LK_SUB || s_ff.st == flash_ctrl_pkg::LK_WDATA)) begin
      nxt_s.sh = {s_ff.sh[6:0], s_ff.sda2};
      nxt_s.cnt = s_ff.cnt + 4'h1;
    end else if (scl_fall) begin
      case (s_ff.st)
        flash_ctrl_pkg::LK_DEV: begin
          if (s_ff.cnt == 4'h8) begin
            if (s_ff.sh[7:1] == `DEV_ADDR) begin
              nxt_s.sda_oe = 1'b1;
              nxt_s.rw = s_ff.sh[0];
              nxt_s.st = flash_ctrl_pkg::LK_ACK_DEV;
              if (s_ff.sh[0]) begin
                nxt_s.rd_tgl = ~s_ff.rd_tgl;
              end
            end else begin
              nxt_s.st = flash_ctrl_pkg::LK_IDLE;
            end
          end
        end
        flash_ctrl_pkg::LK_SUB: begin
          if (s_ff.cnt == 4'h8) begin
            nxt_s.sub = s_ff.sh;
            nxt_s.sda_oe = 1'b1;
            nxt_s.st = flash_ctrl_pkg::LK_ACK_SUB;
          end
        end
        flash_ctrl_pkg::LK_WDATA: begin
          if (s_ff.cnt == 4'h8) begin
            nxt_s.wr_data = s_ff.sh;
            nxt_s.wr_tgl = ~s_ff.wr_tgl;
            nxt_s.sda_oe = 1'b1;
            nxt_s.st = flash_ctrl_pkg::LK_ACK_WR;
          end
        end
        flash_ctrl_pkg::LK_ACK_DEV: begin
          nxt_s.cnt = 4'h0;
          if (s_ff.rw) begin
            nxt_s.sh = s_ff.tx;
            nxt_s.sda_oe = ~s_ff.tx[7];
            nxt_s.cnt = 4'h1;
            nxt_s.st = flash_ctrl_pkg::LK_RDATA;
          end else begin
            nxt_s.sda_oe = 1'b0;
            nxt_s.st = flash_ctrl_pkg::LK_SUB;
          end
        end
        flash_ctrl_pkg::LK_ACK_SUB: begin
          nxt_s.sda_oe = 1'b0;
          nxt_s.cnt = 4'h0;
          nxt_s.st = flash_ctrl_pkg::LK_WDATA;
        end
        flash_ctrl_pkg::LK_ACK_WR: begin
          nxt_s.sda_oe = 1'b0;
          nxt_s.st = flash_ctrl_pkg::LK_WAIT;
        end
        flash_ctrl_pkg::LK_RDATA: begin
          if (s_ff.cnt == 4'h8) begin
            nxt_s.sda_oe = 1'b0;
            nxt_s.st = flash_ctrl_pkg::LK_WAIT;
          end else begin
            nxt_s.sda_oe = ~s_ff.sh[6];
            nxt_s.sh = {s_ff.sh[6:0], 1'b0};
            nxt_s.cnt = s_ff.cnt + 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (s_ff.rs2) begin
      s_ff <= '0;
      s_ff.rs1 <= nxt_s.rs1;
      s_ff.rs2 <= nxt_s.rs2;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sda_out = s_ff.sda_lvl;
  assign sda_oe = s_ff.sda_oe;
  assign wr_tgl = s_ff.wr_tgl;
  assign sub_addr = s_ff.sub;
  assign wr_data = s_ff.wr_data;
  assign rd_tgl = s_ff.rd_tgl;
endmodule : i2c_link_slave
`default_nettype wire

// >>> rtl/flash_fault_adc_control.sv
// flash driver control core: registers, converter sequencing, fault collection
// Notes on behaviour
// - converter mode written while output enabled starts that conversion at once
// - mode written while output disabled waits, converts when the later active mode ends
// - a mode write while idle only arms a deferred conversion
// - each conversion leaves a 4-bit code in result bits 5:2 at 0x08
// - code 01 measures led forward voltage; torch result valid 1 ms after start
// - in flash, forward voltage is sampled just before the flash timer expires
// - code 10 measures die temperature, result valid 1 ms after start
// - external voltage converts only when pin two configuration is 11
// - critical fault clears output enable, stops driver, sets its bit at 0x05
// - reading the fault register returns flags then clears them all
// - noncritical events set information bits, driver keeps running, held until read
// - led output short while driver enabled sets bit 6, driver off until register cleared
// - output overvoltage sets bit 7, driver off until cleared
// - bit 7 of 0x07 limits overvoltage instead of faulting
// - level hardware strobe high past flash timer sets bit 4, driver off
// - overtemperature sets bit 5, driver off until cleared
// - indicator pin open or short sets bit 2 without shutdown
// - peak inductor limit sets bit 1; soft keeps running, hard shuts down
// - undervoltage shuts down; recovery returns all registers to defaults
// - enable pin rising edge returns all registers to defaults
// - answers address 0x30; subaddress picks register; acks after data byte
// - light mode codes: 00 standby, 01 5 V, 10 assist, 11 flash
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_consts.svh"
module flash_fault_adc_control #(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter logic [7:0] DESIGN_INFO = 8'h5A // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic en_pin,
  input wire logic uvlo_det,
  input wire logic ovp_det,
  input wire logic led_short_det,
  input wire logic overtemp_det,
  input wire logic ind_led_fault_det,
  input wire logic peak_ilim_det,
  input wire logic tx_mask_one,
  input wire logic tx_mask_two,
  input wire logic dc_limit_det,
  input wire logic strobe_pin,
  input wire logic flash_timer_done,
  input wire logic flash_pre_expiry,
  input wire logic [3:0] adc_code,
  output logic driver_enable,
  output logic five_volt_mode,
  output logic ovp_limit_active,
  output logic adc_run,
  output logic [1:0] adc_channel,
  output logic [7:0] output_control,
  output logic [7:0] indicator_and_protection_config
);
  flash_ctrl_pkg::core_state_type s_ff, nxt_s;
  flash_ctrl_pkg::pins_type pins_now;
  flash_ctrl_pkg::light_mode_type light_mode_field;
  flash_ctrl_pkg::adc_mode_type conv_mode;
  flash_ctrl_pkg::pin_cfg_type pin_two_config;
  logic wr_tgl, rd_tgl;
  logic [7:0] sub_addr, wr_data;
  logic wr_ev, rd_ev, en_rise, uv_fall, conv_wr, mode_ok, active_exit, crit_ev, fault_rd;
  logic timer_rise, pre_rise, conv_start, conv_done;
  logic [7:0] fault_set, crit_mask;

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a <= `REG_LAST) && (a != 8'h01);
  endfunction : reg_mapped

  function automatic logic [9:0][7:0] reg_defaults();
    logic [9:0][7:0] r;
    r = {10{`RST_OTHER}};
    r[`REG_TIMER] = `RST_TIMER;
    r[`REG_CURRENT] = `RST_CURRENT;
    reg_defaults = r;
  endfunction : reg_defaults

  i2c_link_slave u_link (
    .link_clk(link_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_tgl(wr_tgl),
    .sub_addr(sub_addr),
    .wr_data(wr_data),
    .rd_tgl(rd_tgl),
    .rd_data(s_ff.rd_data),
    .rd_ack_tgl(s_ff.rd_ack)
  );

  assign pins_now = '{en: en_pin, uvlo: uvlo_det, ovp: ovp_det, short_det: led_short_det,
                      hot: overtemp_det, ind_fault: ind_led_fault_det, ilim: peak_ilim_det,
                      tx1: tx_mask_one, tx2: tx_mask_two, dclim: dc_limit_det,
                      strobe: strobe_pin, timer_done: flash_timer_done,
                      pre_expiry: flash_pre_expiry, adc_code: adc_code};

  always_comb begin
    nxt_s = s_ff;
    nxt_s.p1 = pins_now;
    nxt_s.p2 = s_ff.p1;
    nxt_s.p3 = s_ff.p2;
    nxt_s.wt1 = wr_tgl;
    nxt_s.wt2 = s_ff.wt1;
    nxt_s.wt3 = s_ff.wt2;
    nxt_s.rt1 = rd_tgl;
    nxt_s.rt2 = s_ff.rt1;
    nxt_s.rt3 = s_ff.rt2;
    wr_ev = s_ff.wt2 ^ s_ff.wt3;
    rd_ev = s_ff.rt2 ^ s_ff.rt3;
    en_rise = s_ff.p2.en & ~s_ff.p3.en;
    uv_fall = ~s_ff.p2.uvlo & s_ff.p3.uvlo;
    timer_rise = s_ff.p2.timer_done & ~s_ff.p3.timer_done;
    pre_rise = s_ff.p2.pre_expiry & ~s_ff.p3.pre_expiry;
    conv_start = 1'b0;
    conv_done = 1'b0;
    // host writes; fault register and result bits are not writable
    conv_wr = wr_ev && (sub_addr == `REG_ADC);
    if (wr_ev && reg_mapped(sub_addr) && sub_addr != `REG_INFO && sub_addr != `REG_FAULT) begin
      if (conv_wr) begin
        nxt_s.regs[`REG_ADC][1:0] = wr_data[1:0];
      end else begin
        nxt_s.regs[sub_addr[3:0]] = wr_data;
      end
    end
    // read answer; fault register empties on the read itself
    fault_rd = rd_ev && (sub_addr == `REG_FAULT);
    if (rd_ev) begin
      nxt_s.rd_ack = ~s_ff.rd_ack;
      if (sub_addr == `REG_INFO) begin
        nxt_s.rd_data = DESIGN_INFO;
      end else if (reg_mapped(sub_addr)) begin
        nxt_s.rd_data = s_ff.regs[sub_addr[3:0]];
      end else begin
        nxt_s.rd_data = 8'h00;
      end
    end
    if (fault_rd) begin
      nxt_s.regs[`REG_FAULT] = 8'h00;
    end
    light_mode_field = flash_ctrl_pkg::light_mode_type'(nxt_s.regs[`REG_OUT_CTL][1:0]);
    pin_two_config = flash_ctrl_pkg::pin_cfg_type'(s_ff.regs[`REG_TIMER][7:`P2_CFG_LO]);
    conv_mode = flash_ctrl_pkg::adc_mode_type'(nxt_s.regs[`REG_ADC][1:0]);
    // fault and information events; a new event outranks the read clear
    fault_set = 8'h00;
    fault_set[`FB_OVP] = s_ff.p2.ovp & ~s_ff.regs[`REG_IND_CFG][`IC_ADAPTIVE_OVERVOLT_MODE];
    fault_set[`FB_SHORT] = s_ff.p2.short_det & s_ff.drv_en;
    fault_set[`FB_HOT] = s_ff.p2.hot;
    fault_set[`FB_TIMEOUT] = timer_rise & s_ff.p2.strobe & s_ff.regs[`REG_OUT_CTL][`OC_HW_STROBE]
                             & s_ff.regs[`REG_OUT_CTL][`OC_LEVEL];
    fault_set[`FB_TXMASK] = s_ff.p2.tx1 | s_ff.p2.tx2;
    fault_set[`FB_INDLED] = s_ff.p2.ind_fault
                            & (pin_two_config == flash_ctrl_pkg::P2_INDICATOR);
    fault_set[`FB_ILIM] = s_ff.p2.ilim;
    fault_set[`FB_DCLIM] = s_ff.p2.dclim;
    crit_mask = 8'hF0;
    crit_mask[`FB_ILIM] = s_ff.regs[`REG_IND_CFG][`IC_HARD_ILIM];
    nxt_s.regs[`REG_FAULT] = nxt_s.regs[`REG_FAULT] | fault_set;
    crit_ev = |(fault_set & crit_mask);
    if (crit_ev || s_ff.p2.uvlo) begin
      nxt_s.regs[`REG_OUT_CTL][`OC_OUT_EN] = 1'b0;
    end
    // driver held off while any critical bit stays unread
    nxt_s.drv_en = nxt_s.regs[`REG_OUT_CTL][`OC_OUT_EN]
                   & ~|(nxt_s.regs[`REG_FAULT] & crit_mask) & ~s_ff.p2.uvlo;
    nxt_s.five_v = nxt_s.drv_en & (light_mode_field == flash_ctrl_pkg::LM_FIVE_VOLT);
    nxt_s.ovp_lim = s_ff.p2.ovp & s_ff.regs[`REG_IND_CFG][`IC_ADAPTIVE_OVERVOLT_MODE] & s_ff.drv_en;
    active_exit = s_ff.drv_en & ~nxt_s.drv_en;
    mode_ok = (conv_mode != flash_ctrl_pkg::ADC_OFF) &&
              (conv_mode != flash_ctrl_pkg::ADC_EXT ||
               pin_two_config == flash_ctrl_pkg::P2_ANALOG);
    case (s_ff.conv_st)
      flash_ctrl_pkg::CV_IDLE, flash_ctrl_pkg::CV_ARMED: begin
        if (conv_wr && !mode_ok) begin
          nxt_s.conv_st = flash_ctrl_pkg::CV_IDLE;
        end else if (conv_wr && !s_ff.drv_en) begin
          nxt_s.conv_st = flash_ctrl_pkg::CV_ARMED;
        end else if (conv_wr) begin
          if (conv_mode == flash_ctrl_pkg::ADC_LED_VF
              && light_mode_field == flash_ctrl_pkg::LM_FLASH) begin
            nxt_s.conv_st = flash_ctrl_pkg::CV_WAIT_FLASH;
            nxt_s.adc_run = 1'b1;
            nxt_s.adc_chan = conv_mode;
          end else begin
            conv_start = 1'b1;
          end
        end else if (s_ff.conv_st == flash_ctrl_pkg::CV_ARMED && active_exit) begin
          conv_start = 1'b1;
        end
      end
      flash_ctrl_pkg::CV_WAIT_FLASH: begin
        // sample while the timed pulse is still running
        if (pre_rise || active_exit) begin
          conv_done = 1'b1;
        end
      end
      flash_ctrl_pkg::CV_CONV: begin
        if (s_ff.cnt == 17'(CONV_CYCLES - 1)) begin
          conv_done = 1'b1;
        end else begin
          nxt_s.cnt = s_ff.cnt + 17'h0_0001;
        end
      end
      default: begin
        nxt_s.conv_st = flash_ctrl_pkg::CV_IDLE;
      end
    endcase
    if (conv_start) begin
      nxt_s.conv_st = flash_ctrl_pkg::CV_CONV;
      nxt_s.cnt = 17'h0_0000;
      nxt_s.adc_run = 1'b1;
      nxt_s.adc_chan = conv_mode;
    end
    if (conv_done) begin
      nxt_s.regs[`REG_ADC][5:`RES_LO] = s_ff.p2.adc_code;
      nxt_s.conv_st = flash_ctrl_pkg::CV_IDLE;
      nxt_s.adc_run = 1'b0;
    end
    // enable pin edge or supply recovery return registers to defaults
    if (en_rise || uv_fall) begin
      nxt_s.regs = reg_defaults();
      nxt_s.drv_en = 1'b0;
      nxt_s.five_v = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.regs <= reg_defaults();
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign driver_enable = s_ff.drv_en;
  assign five_volt_mode = s_ff.five_v;
  assign ovp_limit_active = s_ff.ovp_lim;
  assign adc_run = s_ff.adc_run;
  assign adc_channel = s_ff.adc_chan;
  assign output_control = s_ff.regs[`REG_OUT_CTL];
  assign indicator_and_protection_config = s_ff.regs[`REG_IND_CFG];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  crit_clears_enable_a: assert property (crit_ev && !en_rise |=>
    !output_control[`OC_OUT_EN] && !driver_enable)
    else $error("critical fault left output enabled");
  short_sets_bit_a: assert property (fault_set[`FB_SHORT] && !en_rise && !uv_fall |=>
    s_ff.regs[`REG_FAULT][`FB_SHORT])
    else $error("short event did not set its fault bit");
  fault_holds_off_a: assert property (|(s_ff.regs[`REG_FAULT] & crit_mask) && !fault_rd
    |=> !driver_enable)
    else $error("driver enabled with critical fault pending");
  read_clears_a: assert property (fault_rd && fault_set == 8'h00 |=>
    s_ff.regs[`REG_FAULT] == 8'h00)
    else $error("fault register not cleared by read");
  adaptive_overvolt_mode_no_fault_a: assert property (s_ff.p2.ovp && output_control != 8'h00 &&
    indicator_and_protection_config[`IC_ADAPTIVE_OVERVOLT_MODE] && !s_ff.regs[`REG_FAULT][`FB_OVP]
    && !wr_ev |=> !s_ff.regs[`REG_FAULT][`FB_OVP])
    else $error("overvoltage faulted in adaptive mode");
  immediate_conv_a: assert property (conv_wr && mode_ok && s_ff.drv_en &&
    conv_mode == flash_ctrl_pkg::ADC_DIE_TEMP && !en_rise |=> adc_run ##1 adc_run)
    else $error("enabled converter write did not start");
  idle_arms_a: assert property (conv_wr && !s_ff.drv_en && s_ff.conv_st !=
    flash_ctrl_pkg::CV_CONV |=> !adc_run && s_ff.conv_st != flash_ctrl_pkg::CV_CONV)
    else $error("idle converter write converted at once");
  result_held_a: assert property (!conv_done && !en_rise && !uv_fall && !rst |=>
    $stable(s_ff.regs[`REG_ADC][5:2]))
    else $error("result changed without a finished conversion");
  en_defaults_a: assert property (en_rise |=> output_control == `RST_OTHER &&
    s_ff.regs[`REG_TIMER] == `RST_TIMER && !driver_enable)
    else $error("enable edge did not restore defaults");

  conv_done_c: cover property (s_ff.conv_st == flash_ctrl_pkg::CV_CONV ##1 conv_done);
  deferred_c: cover property (s_ff.conv_st == flash_ctrl_pkg::CV_ARMED && active_exit);
  flash_sample_c: cover property (s_ff.conv_st == flash_ctrl_pkg::CV_WAIT_FLASH && pre_rise);
  fault_read_c: cover property (fault_rd && s_ff.regs[`REG_FAULT] != 8'h00);
endmodule : flash_fault_adc_control
`default_nettype wire

// >>> testbench/i2c_host_model.sv
// serial host model driving the clock directly and pulling the open-drain data line
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // clock stands high between frames, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    sda_pull = !b;
    #250 scl = 1'b1;
    #500 s = sda;
    scl = 1'b0;
    #250;
  endtask : bit_io
  // serves as repeated start too, since clock is low then
  task automatic start();
    sda_pull = 1'b0;
    #250 scl = 1'b1;
    #500 sda_pull = 1'b1;
    #500 scl = 1'b0;
    #250;
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    #250 scl = 1'b1;
    #500 sda_pull = 1'b0;
    #500;
  endtask : stop
  // ninth bit always released: slave ack on writes, host nack on reads
  task automatic byte_io(input logic [7:0] t, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(t[i], r[i]);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : byte_io
  task automatic wr(input logic [7:0] sub, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    byte_io(8'h60, r, a0);
    byte_io(sub, r, a1);
    byte_io(d, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr
  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    start();
    byte_io(8'h60, r, a);
    byte_io(sub, r, a);
    start();
    byte_io(8'h61, r, a);
    byte_io(8'hFF, d, a);
    stop();
  endtask : rd
endmodule : i2c_host_model
`default_nettype wire

// >>> testbench/tb_top.sv
// bench: register traffic over the serial link, converter and fault checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic en_pin = 1'b1;
  logic uvlo_det = 1'b0;
  logic strobe_pin = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [3:0] code = 4'h0;
  logic pre = 1'b0;
  logic scl, pull, sda_oe, ok, driver_enable, five_volt_mode, ovp_limit_active, adc_run;
  logic [1:0] adc_channel;
  logic [7:0] output_control, indicator_and_protection_config, rd_v;
  int err_total = 0;
  int samples_checked = 0;
  wire sda = !(sda_oe | pull);
  always #12.5 clk = !clk;
  // unrelated phase to the core clock
  initial begin
    #7;
    forever #32 link_clk = !link_clk;
  end
  i2c_host_model i_i2c_host_model (.scl(scl), .sda_pull(pull), .sda(sda));
  flash_fault_adc_control #(.CONV_CYCLES(200)) i_flash_fault_adc_control (
    .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(sda_oe), .en_pin(en_pin), .uvlo_det(uvlo_det), .ovp_det(ev[7]),
    .led_short_det(ev[6]), .overtemp_det(ev[5]), .ind_led_fault_det(ev[2]),
    .peak_ilim_det(ev[1]), .tx_mask_one(ev[3]), .tx_mask_two(ev[3]), .dc_limit_det(ev[0]),
    .strobe_pin(strobe_pin), .flash_timer_done(ev[4]), .flash_pre_expiry(pre),
    .adc_code(code), .driver_enable(driver_enable), .five_volt_mode(five_volt_mode),
    .ovp_limit_active(ovp_limit_active), .adc_run(adc_run), .adc_channel(adc_channel),
    .output_control(output_control),
    .indicator_and_protection_config(indicator_and_protection_config));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_i2c_host_model.wr(a, d, ok);
    `CHK(ok, 1'b1)
    cyc(20);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    i_i2c_host_model.rd(a, rd_v);
    `CHK(rd_v & m, e)
    cyc(2);
  endtask : r
  task automatic conv_done(input logic [1:0] ch);
    int n;
    n = 0;
    `CHK(adc_run, 1'b1)
    `CHK(adc_channel, ch)
    while (adc_run !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    `CHK(adc_run, 1'b0)
  endtask : conv_done
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    // about 75k clk of traffic expected; stays under 96k
    #2400us;
    err_total++;
    finish_test();
  end
  initial begin
    logic [7:0] crit;
    crit = 8'hF0;
    cyc(16);
    rst = 1'b0;
    cyc(30);
    r(8'h02, 8'h0F, 8'hFF);
    r(8'h03, 8'h03, 8'hFF);
    r(8'h0C, 8'h00, 8'hFF);
    code = 4'hA;
    w(8'h04, 8'h0A);
    `CHK(driver_enable, 1'b1)
    w(8'h08, 8'h02);
    conv_done(2'd2);
    code = 4'h3;
    cyc(20);
    r(8'h08, 8'h28, 8'h3C);
    w(8'h08, 8'h03);
    `CHK(adc_run, 1'b0)
    w(8'h02, 8'hCF);
    w(8'h08, 8'h03);
    conv_done(2'd3);
    r(8'h08, 8'h0C, 8'h3C);
    code = 4'h5;
    w(8'h04, 8'h02);
    w(8'h08, 8'h01);
    `CHK(adc_run, 1'b0)
    w(8'h04, 8'h0A);
    `CHK(adc_run, 1'b0)
    w(8'h04, 8'h02);
    conv_done(2'd1);
    r(8'h08, 8'h14, 8'h3C);
    w(8'h08, 8'h00);
    w(8'h04, 8'h01);
    w(8'h04, 8'h09);
    `CHK(five_volt_mode, 1'b1)
    w(8'h04, 8'h00);
    code = 4'h7;
    w(8'h04, 8'h0B);
    w(8'h08, 8'h01);
    `CHK(adc_run, 1'b1)
    `CHK(adc_channel, 2'd1)
    pre = 1'b1;
    cyc(6);
    pre = 1'b0;
    `CHK(adc_run, 1'b0)
    w(8'h04, 8'h00);
    r(8'h08, 8'h1C, 8'h3C);
    // indicator configuration so the pin two fault is counted
    w(8'h02, 8'h4F);
    for (int i = 0; i < 8; i++) begin
      w(8'h04, (i == 4) ? 8'h2F : 8'h0A);
      strobe_pin = (i == 4);
      cyc(4);
      ev[i] = 1'b1;
      cyc(10);
      ev[i] = 1'b0;
      strobe_pin = 1'b0;
      cyc(5);
      `CHK(driver_enable, !crit[i])
      `CHK(output_control[3], !crit[i])
      r(8'h05, 8'h01 << i, 8'hFF);
      r(8'h05, 8'h00, 8'hFF);
    end
    w(8'h07, 8'h80);
    w(8'h04, 8'h0A);
    ev[7] = 1'b1;
    cyc(10);
    `CHK(ovp_limit_active, 1'b1)
    ev[7] = 1'b0;
    r(8'h05, 8'h00, 8'h80);
    `CHK(indicator_and_protection_config, 8'h80)
    en_pin = 1'b0;
    cyc(5);
    en_pin = 1'b1;
    cyc(10);
    `CHK(indicator_and_protection_config, 8'h00)
    `CHK(output_control, 8'h00)
    w(8'h07, 8'h80);
    w(8'h04, 8'h0A);
    uvlo_det = 1'b1;
    cyc(10);
    `CHK(driver_enable, 1'b0)
    uvlo_det = 1'b0;
    cyc(10);
    `CHK(indicator_and_protection_config, 8'h00)
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
